// [src/timer_pair.sv]
`timescale 1ns/1ps
module timer_pair (
	input  wire logic                      mclk,
	input  wire logic                      rst_b,
	input  wire timer_pair_pkg::sfr_req_t  sfr_req,
	output logic      [7:0]                sfr_rdata,
	input  wire logic                      t0_run,
	input  wire logic                      t1_run,
	input  wire logic                      t0_flag_clr,
	input  wire logic                      t1_flag_clr,
	input  wire logic                      t0_gate_pin,
	input  wire logic                      t1_gate_pin,
	input  wire logic                      t0_count_pin,
	input  wire logic                      t1_count_pin,
	output logic                           t0_overflow_flag,
	output logic                           t1_overflow_flag
);

	timer_pair_pkg::timer_state_t q;
	timer_pair_pkg::timer_state_t d;

	logic [3:0] pin_level;
	logic [3:0] pin_fall;
	logic [1:0] flag_q;
	logic [1:0] flag_set;

	logic       tick_now;
	logic       t0_split;
	logic       t1_halted;
	logic       run0;
	logic       run1;
	logic       inc0;
	logic       inc1;
	logic       inc0_high;
	logic       ovf0;
	logic       ovf1;
	logic       ovf0_high;
	logic [16:0] adv0;
	logic [16:0] adv1;
	logic [8:0] low_sum;
	logic [8:0] high_sum;

	// bit order: t1 count, t0 count, t1 gate, t0 gate
	pin_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.pin_raw  ({t1_count_pin, t0_count_pin, t1_gate_pin, t0_gate_pin}),
		.pin_level(pin_level),
		.pin_fall (pin_fall)
	);

	overflow_flags u_overflow_flags (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.flag_set(flag_set),
		.flag_clr({t1_flag_clr, t0_flag_clr}),
		.flag_q  (flag_q)
	);

	assign t0_overflow_flag = flag_q[0];
	assign t1_overflow_flag = flag_q[1];
	assign sfr_rdata        = q.rdata;

	// one count step in modes 0..2; result is {overflow, high, low}
	function automatic logic [16:0] advance(
		input logic [1:0] mode,
		input logic [7:0] low,
		input logic [7:0] high
	);
		logic [16:0] r;
		logic [4:0]  pre;
		r   = {1'b0, high, low};
		pre = low[4:0] + 5'h01;
		unique case (mode)
			timer_pair_pkg::MODE_13BIT:
			begin
				// bits 7:5 of the low byte are left alone
				r[7:0] = {low[7:5], pre}; // RL5
				if (low[4:0] == timer_pair_pkg::PRESCALE_TOP)
				begin
					r[15:8] = high + 8'h01; // RL5
					r[16]   = (high == timer_pair_pkg::BYTE_TOP); // RL11
				end
			end
			timer_pair_pkg::MODE_16BIT:
			begin
				r = {1'b0, high, low} + 17'h0_0001; // RL4
			end
			timer_pair_pkg::MODE_RELOAD:
			begin
				if (low == timer_pair_pkg::BYTE_TOP)
				begin
					r[7:0] = high; // RL15
					r[16]  = 1'b1; // RL11
				end
				else
				begin
					r[7:0] = low + 8'h01;
				end
			end
			timer_pair_pkg::MODE_SPLIT:
			begin
				r = {1'b0, high, low};
			end
		endcase
		return r;
	endfunction

	always_comb
	begin
		d        = q;
		tick_now = (q.tick == timer_pair_pkg::TICK_LAST);
		d.tick   = tick_now ? 3'h0 : q.tick + 3'h1;

		t0_split  = (q.mode.t0.mode == timer_pair_pkg::MODE_SPLIT); // RL6
		t1_halted = (q.mode.t1.mode == timer_pair_pkg::MODE_SPLIT); // RL10

		run0 = t0_run & (~q.mode.t0.pin_gating | pin_level[0]); // RL2
		// with timer 0 split, timer 1 loses its run bit to timer 0's high byte
		run1 = (t0_split | t1_run) & (~q.mode.t1.pin_gating | pin_level[1]); // RL1 RL12

		inc0      = run0 & (q.mode.t0.counter_select ? pin_fall[2] : tick_now); // RL3 RL14
		inc1      = run1 & ~t1_halted
		            & (q.mode.t1.counter_select ? pin_fall[3] : tick_now); // RL3 RL10
		inc0_high = t0_split & t1_run & tick_now; // RL12

		adv0      = advance(q.mode.t0.mode, q.t0_low, q.t0_high);
		adv1      = advance(q.mode.t1.mode, q.t1_low, q.t1_high);
		low_sum   = {1'b0, q.t0_low} + 9'h001;
		high_sum  = {1'b0, q.t0_high} + 9'h001;
		ovf0      = 1'b0;
		ovf1      = 1'b0;
		ovf0_high = 1'b0;

		if (inc0)
		begin
			if (t0_split)
			begin
				d.t0_low = low_sum[7:0]; // RL6
				ovf0     = low_sum[8]; // RL11
			end
			else
			begin
				d.t0_low  = adv0[7:0];
				d.t0_high = adv0[15:8];
				ovf0      = adv0[16]; // RL11
			end
		end

		if (inc0_high)
		begin
			d.t0_high = high_sum[7:0]; // RL6
			ovf0_high = high_sum[8];
		end

		if (inc1)
		begin
			d.t1_low  = adv1[7:0];
			d.t1_high = adv1[15:8];
			ovf1      = adv1[16];
		end

		// timer 1 rollover reports nothing while its flag serves timer 0
		flag_set = {t0_split ? ovf0_high : ovf1, ovf0}; // RL11 RL12

		// a software write to a byte beats the count step in the same cycle
		if (sfr_req.wr)
		begin
			unique case (sfr_req.addr)
				timer_pair_pkg::OFS_MODE:
					d.mode = sfr_req.wdata; // RL7 RL13
				timer_pair_pkg::OFS_T0_LOW:
					d.t0_low = sfr_req.wdata; // RL8
				timer_pair_pkg::OFS_T1_LOW:
					d.t1_low = sfr_req.wdata; // RL8
				timer_pair_pkg::OFS_T0_HIGH:
					d.t0_high = sfr_req.wdata; // RL8
				timer_pair_pkg::OFS_T1_HIGH:
					d.t1_high = sfr_req.wdata; // RL8
				default:
				begin
				end
			endcase
		end

		if (sfr_req.rd)
		begin
			unique case (sfr_req.addr)
				timer_pair_pkg::OFS_MODE:
					d.rdata = q.mode; // RL7
				timer_pair_pkg::OFS_T0_LOW:
					d.rdata = q.t0_low; // RL8
				timer_pair_pkg::OFS_T1_LOW:
					d.rdata = q.t1_low; // RL8
				timer_pair_pkg::OFS_T0_HIGH:
					d.rdata = q.t0_high; // RL8
				timer_pair_pkg::OFS_T1_HIGH:
					d.rdata = q.t1_high; // RL8
				default:
					d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q.mode    <= timer_pair_pkg::RST_MODE;
			q.t0_low  <= timer_pair_pkg::RST_COUNT; // RL9
			q.t0_high <= timer_pair_pkg::RST_COUNT; // RL9
			q.t1_low  <= timer_pair_pkg::RST_COUNT;
			q.t1_high <= timer_pair_pkg::RST_COUNT; // RL9
			q.rdata   <= 8'h00;
			q.tick    <= 3'h0;
		end
		else
		begin
			q <= d;
		end
	end

endmodule // timer_pair

// [src/timer_pair_pkg.sv]
// Contract
// [RL1] timer 1 runs on its run bit, or run bit and high gate pin when gated
// [RL2] timer 0 runs on its run bit, or run bit and high gate pin when gated
// [RL3] counter-select clear counts internal ticks, set counts external count pin events
// [RL4] mode field: 00 13-bit, 01 16-bit, 10 8-bit auto-reload, 11 mode 3
// [RL5] mode 0: high byte counts, prescaled by low-byte bits 4:0 modulo 32
// [RL6] timer 0 mode 3: low byte timer/counter, high byte separate 8-bit timer
// [RL7] mode register bits 7:4 timer 1 fields, 3:0 timer 0, gate/select/mode order
// [RL8] each count byte is a separate 8-bit software readable and writable register
// [RL9] timer 0 high, timer 0 low and timer 1 high bytes reset to zero
// [RL10] timer 1 in mode 3 halts and holds its count
// [RL11] rollover from all ones to zero sets that timer's overflow flag
// [RL12] timer 0 mode 3 high byte takes timer 1 overflow flag and run bit
// [RL13] software stops a timer with its run bit before changing its mode
// [RL14] external count input synchronised, one increment per falling edge
// [RL15] mode 2 overflow reloads low byte from high byte, high byte unchanged
package timer_pair_pkg;

	localparam logic [7:0] OFS_MODE     = 8'h89;
	localparam logic [7:0] OFS_T0_LOW   = 8'h8a;
	localparam logic [7:0] OFS_T1_LOW   = 8'h8b;
	localparam logic [7:0] OFS_T0_HIGH  = 8'h8c;
	localparam logic [7:0] OFS_T1_HIGH  = 8'h8d;

	localparam logic [7:0] RST_MODE     = 8'h00;
	localparam logic [7:0] RST_COUNT    = 8'h00;

	localparam logic [1:0] MODE_13BIT   = 2'h0;
	localparam logic [1:0] MODE_16BIT   = 2'h1;
	localparam logic [1:0] MODE_RELOAD  = 2'h2;
	localparam logic [1:0] MODE_SPLIT   = 2'h3;

	localparam logic [4:0] PRESCALE_TOP = 5'h1f;
	localparam logic [7:0] BYTE_TOP     = 8'hff;

	// internal clock tick: one count per machine cycle of this many clocks
	localparam int         TICK_CLOCKS  = 6;
	localparam logic [2:0] TICK_LAST    = 3'(TICK_CLOCKS - 1);

	// per-timer field of the mode register, msb first: gate, select, mode
	typedef struct packed {
		logic       pin_gating;
		logic       counter_select;
		logic [1:0] mode;
	} timer_cfg_t;

	typedef struct packed {
		timer_cfg_t t1;
		timer_cfg_t t0;
	} mode_reg_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		mode_reg_t  mode;
		logic [7:0] t0_low;
		logic [7:0] t0_high;
		logic [7:0] t1_low;
		logic [7:0] t1_high;
		logic [7:0] rdata;
		logic [2:0] tick;
	} timer_state_t;

endpackage

// [src/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             mclk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] pin_raw,
	output logic      [WIDTH-1:0] pin_level,
	output logic      [WIDTH-1:0] pin_fall
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic [2:0] s_q;
			always_ff @(posedge mclk or negedge rst_b)
			begin
				if (!rst_b)
					s_q <= 3'h0;
				else
					s_q <= {s_q[1:0], pin_raw[i]};
			end
			// only stages 1 and 2 feed logic; stage 0 is metastability guard
			assign pin_level[i] = s_q[1];
			assign pin_fall[i]  = s_q[2] & ~s_q[1]; // RL14
		end
	endgenerate

endmodule // pin_sync

// [src/overflow_flags.sv]
`timescale 1ns/1ps
module overflow_flags (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic [1:0] flag_set,
	input  wire logic [1:0] flag_clr,
	output logic      [1:0] flag_q
);

	logic [1:0] flag_d;

	// a rollover landing on the clear cycle must not be lost, so set wins
	always_comb
	begin
		flag_d = (flag_q & ~flag_clr) | flag_set; // RL11
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			flag_q <= 2'h0;
		else
			flag_q <= flag_d;
	end

endmodule // overflow_flags

// [bench/timer_pair_props.sv]
`timescale 1ns/1ps
module timer_pair_props (
	input wire logic                     mclk,
	input wire logic                     rst_b,
	input wire timer_pair_pkg::sfr_req_t sfr_req,
	input wire logic [7:0]               sfr_rdata,
	input wire logic                     t0_run,
	input wire logic                     t1_run,
	input wire logic                     t0_flag_clr,
	input wire logic                     t1_flag_clr,
	input wire logic                     t0_overflow_flag,
	input wire logic                     t1_overflow_flag
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	logic mapped;
	assign mapped = sfr_req.addr >= 8'h89 && sfr_req.addr <= 8'h8d;

	a_unmapped_read: assert property (sfr_req.rd && !mapped |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_stands: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_mode_readback: assert property (sfr_req.wr && sfr_req.addr == 8'h89 ##1 !sfr_req.wr ##1
		sfr_req.rd && !sfr_req.wr && sfr_req.addr == 8'h89 |=> sfr_rdata == $past(sfr_req.wdata, 3))
		else $error("mode register readback wrong");
	a_flag0_sticky: assert property (t0_overflow_flag && !t0_flag_clr |=> t0_overflow_flag)
		else $error("timer 0 flag dropped without clear");
	a_flag1_fall: assert property ($fell(t1_overflow_flag) |-> $past(t1_flag_clr))
		else $error("timer 1 flag dropped without clear");
	a_flag0_run: assert property ($rose(t0_overflow_flag) |-> $past(t0_run))
		else $error("timer 0 flag rose while stopped");
	a_flag1_run: assert property ($rose(t1_overflow_flag) |-> $past(t1_run))
		else $error("timer 1 flag rose while stopped");
	a_stopped_clear: assert property (t0_flag_clr && !t0_run |=> !t0_overflow_flag)
		else $error("timer 0 flag not cleared");
endmodule // timer_pair_props

bind timer_pair timer_pair_props props (
	.mclk, .rst_b, .sfr_req, .sfr_rdata, .t0_run, .t1_run,
	.t0_flag_clr, .t1_flag_clr, .t0_overflow_flag, .t1_overflow_flag
);

// [bench/pin_source.sv]
`timescale 1ns/1ps
module pin_source (
	input  wire logic mclk,
	output logic      t0_gate_pin,
	output logic      t1_gate_pin,
	output logic      t0_count_pin,
	output logic      t1_count_pin
);
	// count inputs idle high so only a commanded pulse makes a falling edge
	initial
	begin
		{t0_gate_pin, t1_gate_pin, t0_count_pin, t1_count_pin} = 4'hf;
	end
	task automatic set_gate(input int i, input logic lvl);
		if (i == 0)
			t0_gate_pin = lvl;
		else
			t1_gate_pin = lvl;
	endtask
	// four clocks a phase outlasts the synchroniser, so each fall is one event
	task automatic pulse0(input int n);
		repeat (n)
		begin
			repeat (4) @(negedge mclk);
			t0_count_pin = 1'b0;
			repeat (4) @(negedge mclk);
			t0_count_pin = 1'b1;
		end
	endtask
	task automatic pulse1(input int n);
		repeat (n)
		begin
			repeat (4) @(negedge mclk);
			t1_count_pin = 1'b0;
			repeat (4) @(negedge mclk);
			t1_count_pin = 1'b1;
		end
	endtask
endmodule // pin_source

// [bench/timer_pair_tb.sv]
`timescale 1ns/1ps
module timer_pair_tb;
	logic                     mclk, rst_b, t0_run, t1_run, t0_flag_clr, t1_flag_clr;
	logic                     t0_gate_pin, t1_gate_pin, t0_count_pin, t1_count_pin;
	logic                     t0_overflow_flag, t1_overflow_flag;
	logic [7:0]               sfr_rdata, rv;
	timer_pair_pkg::sfr_req_t sfr_req;
	int                       bad_count, comparisons, cycles;

	timer_pair dut (.mclk, .rst_b, .sfr_req, .sfr_rdata, .t0_run, .t1_run, .t0_flag_clr,
		.t1_flag_clr, .t0_gate_pin, .t1_gate_pin, .t0_count_pin, .t1_count_pin,
		.t0_overflow_flag, .t1_overflow_flag);
	pin_source far (.mclk, .t0_gate_pin, .t1_gate_pin, .t0_count_pin, .t1_count_pin);

	always #2.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			bad_count++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (bad_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function automatic logic [7:0] flags();
		return {6'h00, t1_overflow_flag, t0_overflow_flag};
	endfunction
	// one request cycle then one idle cycle, so read data has landed on return
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		sfr_req = '{addr: a, wr: w, rd: !w, wdata: d};
		@(negedge mclk);
		sfr_req = '0;
		@(negedge mclk);
		rv = sfr_rdata;
	endtask
	task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
		bus(a, 1'b0, 8'h00);
		chk(name, rv, exp);
	endtask
	// six clocks per internal tick: a window of 6n clocks holds exactly n ticks
	task automatic run(input logic r0, input logic r1, input int n);
		t0_run = r0;
		t1_run = r1;
		repeat (6 * n) @(negedge mclk);
		t0_run = 1'b0;
		t1_run = 1'b0;
		@(negedge mclk);
	endtask
	task automatic clr();
		{t0_flag_clr, t1_flag_clr} = 2'h3;
		@(negedge mclk);
		{t0_flag_clr, t1_flag_clr} = 2'h0;
		@(negedge mclk);
	endtask

	task automatic t_regs();
		for (int i = 0; i < 5; i++)
			rchk("reset", 8'h89 + 8'(i), 8'h00);
		rchk("unmapped", 8'h88, 8'h00);
		// read straight back after each write so the mode readback property sees it
		for (int i = 0; i < 5; i++)
		begin
			bus(8'h89 + 8'(i), 1'b1, 8'h3c + 8'(i));
			rchk("written", 8'h89 + 8'(i), 8'h3c + 8'(i));
		end
		bus(8'h8e, 1'b1, 8'h77);
		rchk("unmapped write", 8'h8e, 8'h00);
		for (int i = 0; i < 5; i++)
			rchk("readback", 8'h89 + 8'(i), 8'h3c + 8'(i));
	endtask
	task automatic t_modes();
		logic [7:0] tab [3][5] = '{'{8'h00, 8'h3f, 8'hff, 8'h20, 8'h00},
			'{8'h01, 8'hff, 8'hff, 8'h00, 8'h00}, '{8'h02, 8'hff, 8'h80, 8'h80, 8'h80}};
		for (int m = 0; m < 3; m++)
		begin
			bus(8'h89, 1'b1, tab[m][0]);
			bus(8'h8a, 1'b1, tab[m][1]);
			bus(8'h8c, 1'b1, tab[m][2]);
			run(1'b1, 1'b0, 1);
			rchk("low", 8'h8a, tab[m][3]);
			rchk("high", 8'h8c, tab[m][4]);
			chk("flag set", flags(), 8'h01);
			clr();
			chk("flag clear", flags(), 8'h00);
		end
	endtask
	task automatic t_count();
		bus(8'h89, 1'b1, 8'h0d);
		bus(8'h8a, 1'b1, 8'h00);
		far.set_gate(0, 1'b0);
		t0_run = 1'b1;
		far.pulse0(2);
		rchk("gated", 8'h8a, 8'h00);
		far.set_gate(0, 1'b1);
		far.pulse0(3);
		rchk("events", 8'h8a, 8'h03);
		t0_run = 1'b0;
		@(negedge mclk);
	endtask
	task automatic t_t1();
		bus(8'h89, 1'b1, 8'h10);
		bus(8'h8b, 1'b1, 8'h00);
		run(1'b0, 1'b1, 2);
		rchk("t1 run", 8'h8b, 8'h02);
		far.set_gate(1, 1'b0);
		bus(8'h89, 1'b1, 8'h90);
		run(1'b0, 1'b1, 2);
		rchk("t1 gated", 8'h8b, 8'h02);
		bus(8'h89, 1'b1, 8'h30);
		run(1'b0, 1'b1, 2);
		rchk("t1 hold", 8'h8b, 8'h02);
		bus(8'h89, 1'b1, 8'h60);
		bus(8'h8b, 1'b1, 8'hff);
		bus(8'h8d, 1'b1, 8'ha5);
		t1_run = 1'b1;
		far.pulse1(1);
		t1_run = 1'b0;
		rchk("t1 reload low", 8'h8b, 8'ha5);
		rchk("t1 reload high", 8'h8d, 8'ha5);
		chk("t1 flag", flags(), 8'h02);
		clr();
	endtask
	task automatic t_split();
		bus(8'h89, 1'b1, 8'h03);
		bus(8'h8a, 1'b1, 8'h10);
		bus(8'h8c, 1'b1, 8'hff);
		run(1'b0, 1'b1, 1);
		rchk("split low", 8'h8a, 8'h10);
		rchk("split high", 8'h8c, 8'h00);
		chk("split flags", flags(), 8'h02);
		run(1'b1, 1'b0, 1);
		rchk("split low run", 8'h8a, 8'h11);
		rchk("split high hold", 8'h8c, 8'h00);
		clr();
	endtask
	// reset dropped while timer 0 is counting, bytes preloaded non-zero
	task automatic t_reset();
		bus(8'h8c, 1'b1, 8'h55);
		bus(8'h8d, 1'b1, 8'h66);
		t0_run = 1'b1;
		repeat (3) @(negedge mclk);
		rst_b = 1'b0;
		repeat (2) @(negedge mclk);
		rst_b = 1'b1;
		t0_run = 1'b0;
		rchk("reset low", 8'h8a, 8'h00);
		rchk("reset high", 8'h8c, 8'h00);
		rchk("reset t1 high", 8'h8d, 8'h00);
		chk("reset flags", flags(), 8'h00);
	endtask

	initial
	begin
		{mclk, rst_b, t0_run, t1_run, t0_flag_clr, t1_flag_clr} = 6'h00;
		sfr_req = '0;
		bad_count = 0;
		comparisons = 0;
		cycles = 0;
		repeat (20) @(negedge mclk);
		rst_b = 1'b1;
		t_regs();
		t_modes();
		t_count();
		t_t1();
		t_split();
		t_reset();
		end_sim();
	end
endmodule // timer_pair_tb
